// >>> hw/isp_port_control.sv
// Serial test port control: pin ownership, command decode, status pins.
// Assumes the test pins arrive unsynchronised and the memory controller,
// register port and logic product term run on the same clock.
//
// Functional notes
// R1: Pins enabled when nonvolatile bit, runtime bit or product term is set.
// R2: When not enabled, the four test pins return to general port use.
// R3: Nonvolatile dedication keeps the pins for the test port regardless.
// R4: All pins start as inputs; output drives only after the entry command.
// R5: Entry command may also enable the busy and error extension pins.
// R6: Runtime enable register at offset C7h; writing one enables the port.
// R7: Device reset clears the runtime bit; software may clear it by writing.
// R8: A logic product term can enable the pins for multiplexed use.
// R9: External setup should tie product term to the cable enable line.
// R10: Blank device has the four basic test pins enabled, unconfigured.
// R11: Configuration commands supported; boundary-scan instructions are not.
// R12: Extension pins report program and erase status directly when enabled.
// R13: Error pin goes low on flash erase/program failure until cleared.
// R14: EEPROM write failures never drive the error pin.
// R15: Status pin high when memories are in read mode.
// R16: Status pin low during flash program/erase or EEPROM writes.
// R17: Entry command can make status and error pins open-drain.
// R18: Bit 0 of runtime register enables the port; other bits unused.
// R19: Device reset aborts runtime-enabled operations, not dedicated ones.
// R20: Standard port state machine on clock rises, output on falls.
module isp_port_control
   import isp_port_pkg::*;
#(
   parameter int DR_WIDTH = 8
) (
   input wire logic clock,                 // 200 MHz system clock
   input wire logic rst_n,                 // Synchronous reset, active low
   input wire logic deviceReset_n,         // Device reset pin, raw
   input wire logic nvmDedicateBit,        // Nonvolatile dedication bit
   input wire logic blankDevice,           // Device is erased or unprogrammed
   input wire logic pinEnableProductTerm,  // Logic product term enable
   input wire logic [7:0] regAddr,         // Offset from control_block_base
   input wire logic regWrite,              // Register write strobe
   input wire logic regRead,               // Register read strobe
   input wire logic [7:0] regWdata,        // Register write data
   output logic [7:0] regRdata,            // Register read data
   input wire logic tckPin,                // Test clock pin, raw
   input wire logic tmsPin,                // Test mode select pin, raw
   input wire logic tdiPin,                // Test data in pin, raw
   output logic tdoOut,                    // Test data out level
   output logic tdoOe_n,                   // Test data out enable, low drives
   output logic pinsActive,                // Test port owns the four pins
   input wire logic flashBusy,             // Flash program or erase running
   input wire logic eepromBusy,            // EEPROM write running
   input wire logic flashEraseFail,        // Flash sector erase failed pulse
   input wire logic flashProgFail,         // Flash byte program failed pulse
   input wire logic eepromFail,            // EEPROM write failed pulse
   output logic progBusyStatusOut,         // Busy/ready pin level
   output logic progBusyStatusOe_n,        // Busy/ready enable, low drives
   output logic progErrorOut,              // Error pin level, low is error
   output logic progErrorOe_n,             // Error pin enable, low drives
   output logic configMode,                // Configuration mode active
   output logic iscWriteStrobe,            // Program byte request pulse
   output logic iscEraseStrobe,            // Erase sector request pulse
   output logic [DR_WIDTH-1:0] iscData     // Data for program or erase
);
   logic [3:0] pinSynced;
   logic tckSync, tmsSync, tdiSync, devResetActive;
   logic tckLast, tckRise, tckFall;
   tapState_t tapState;
   logic runtimeEn, dedicated, tapForce;
   logic [IR_WIDTH-1:0] irShift, irActive;
   logic [DR_WIDTH-1:0] drShift;
   logic bypassBit;
   logic tdoEnabled, extEnable, openDrain, exitPending;
   logic errFlag, ready, statusLevel, errorLevel;
   logic entryUpdate, clearCmd, errSet, errClear, regHit;

   // Bits 0 and 1 of the data register carry fields
   if (DR_WIDTH < 2) begin : badWidth
      $error("isp_port_control: DR_WIDTH below 2");
   end

   pin_sync #(.WIDTH(4)) pinSync (
      .clock(clock),
      .rst_n(rst_n),
      .async({deviceReset_n, tdiPin, tmsPin, tckPin}),
      .synced(pinSynced)
   );

   assign tckSync = pinSynced[0];
   assign tmsSync = pinSynced[1];
   assign tdiSync = pinSynced[2];
   assign devResetActive = !pinSynced[3];

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tckLast <= 1'b0;
      end else begin
         tckLast <= tckSync;
      end
   end

   // Edges are ignored while the port does not own the pins
   assign tckRise = pinsActive && tckSync && !tckLast;
   assign tckFall = pinsActive && !tckSync && tckLast;

   // Pin ownership
   assign dedicated = nvmDedicateBit || blankDevice; // R3 R10
   assign pinsActive = dedicated || runtimeEn || pinEnableProductTerm; // R1 R8
   // Reset only disturbs a port that is not dedicated
   assign tapForce = !pinsActive || (devResetActive && !dedicated); // R2 R19

   tap_fsm tap (
      .clock(clock),
      .rst_n(rst_n),
      .tckRise(tckRise),
      .tms(tmsSync),
      .forceReset(tapForce),
      .state(tapState)
   );

   // Runtime enable register
   assign regHit = (regAddr == RUNTIME_ENABLE_OFFSET);

   always_ff @(posedge clock) begin
      if (!rst_n || devResetActive) begin
         runtimeEn <= RUNTIME_ENABLE_RESET[RUNTIME_ENABLE_BIT]; // R7
      end else if (regWrite && regHit) begin
         runtimeEn <= regWdata[RUNTIME_ENABLE_BIT]; // R6 R18
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         regRdata <= UNMAPPED_READ_VALUE;
      end else if (regRead && regHit) begin
         regRdata <= {7'h00, runtimeEn}; // R18
      end else if (regRead) begin
         regRdata <= UNMAPPED_READ_VALUE;
      end
   end

   // Instruction register
   always_ff @(posedge clock) begin
      if (!rst_n || tapForce) begin
         irShift <= IR_CAPTURE_PATTERN;
         irActive <= CMD_BYPASS;
      end else if (tckRise) begin
         case (tapState)
            TAP_RESET: irActive <= CMD_BYPASS;
            CAP_IR: irShift <= IR_CAPTURE_PATTERN;
            SHIFT_IR: irShift <= {tdiSync, irShift[IR_WIDTH-1:1]}; // R20
            UPD_IR: irActive <= irShift;
            default: irActive <= irActive;
         endcase
      end
   end

   // Data registers; boundary-scan opcodes fall through to bypass
   always_ff @(posedge clock) begin
      if (!rst_n || tapForce) begin
         drShift <= '0;
         bypassBit <= 1'b0;
      end else if (tckRise && tapState == CAP_DR) begin
         bypassBit <= 1'b0;
         drShift <= '0;
         case (irActive)
            CMD_READ_STATUS: begin
               drShift[STAT_READY_BIT] <= ready;
               drShift[STAT_ERROR_BIT] <= errFlag;
            end
            CMD_CONFIG_ENTRY: begin
               drShift[CFG_EXT_ENABLE_BIT] <= extEnable;
               drShift[CFG_OPEN_DRAIN_BIT] <= openDrain;
            end
            default: drShift <= '0; // R11
         endcase
      end else if (tckRise && tapState == SHIFT_DR) begin
         bypassBit <= tdiSync;
         drShift <= {tdiSync, drShift[DR_WIDTH-1:1]};
      end
   end

   // Output pin changes only on falling test clock edges
   always_ff @(posedge clock) begin
      if (!rst_n || tapForce) begin
         tdoOut <= 1'b1;
      end else if (tckFall) begin
         case (tapState)
            SHIFT_IR: tdoOut <= irShift[0]; // R20
            SHIFT_DR: begin
               case (irActive)
                  CMD_CONFIG_ENTRY, CMD_PROGRAM_BYTE, CMD_ERASE_SECTOR,
                  CMD_READ_STATUS: tdoOut <= drShift[0];
                  default: tdoOut <= bypassBit;
               endcase
            end
            default: tdoOut <= tdoOut;
         endcase
      end
   end

   assign entryUpdate = tckRise && tapState == UPD_DR
      && irActive == CMD_CONFIG_ENTRY;
   assign clearCmd = tckRise && tapState == UPD_IR
      && irShift == CMD_ERROR_CLEAR && configMode;

   // Configuration mode and pin turnaround
   always_ff @(posedge clock) begin
      if (!rst_n || tapForce) begin
         configMode <= 1'b0;
         tdoEnabled <= 1'b0;
         extEnable <= 1'b0;
         openDrain <= 1'b0;
      end else if (entryUpdate) begin
         configMode <= 1'b1;
         tdoEnabled <= 1'b1; // R4
         extEnable <= drShift[CFG_EXT_ENABLE_BIT]; // R5
         openDrain <= drShift[CFG_OPEN_DRAIN_BIT]; // R17
      end else if (tckRise && tapState == UPD_IR
            && irShift == CMD_CONFIG_EXIT) begin
         configMode <= 1'b0;
         extEnable <= 1'b0;
      end
   end

   // An exit arms the reset that may clear the error flag
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         exitPending <= 1'b0;
      end else if (tckRise && tapState == UPD_IR
            && irShift == CMD_CONFIG_EXIT) begin
         exitPending <= 1'b1;
      end else if (devResetActive || entryUpdate) begin
         exitPending <= 1'b0;
      end
   end

   assign tdoOe_n = !(pinsActive && tdoEnabled); // R4

   // Program and erase requests to the memory controller
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         iscWriteStrobe <= 1'b0;
         iscEraseStrobe <= 1'b0;
         iscData <= '0;
      end else begin
         iscWriteStrobe <= 1'b0;
         iscEraseStrobe <= 1'b0;
         if (tckRise && tapState == UPD_DR && configMode && !tapForce) begin
            iscData <= drShift; // R11
            iscWriteStrobe <= (irActive == CMD_PROGRAM_BYTE);
            iscEraseStrobe <= (irActive == CMD_ERASE_SECTOR);
         end
      end
   end

   // Sticky error; a failure in the clearing cycle still sets it
   assign errSet = flashEraseFail || flashProgFail; // R13 R14
   assign errClear = clearCmd || (exitPending && devResetActive); // R13

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         errFlag <= 1'b0;
      end else if (errSet) begin
         errFlag <= 1'b1;
      end else if (errClear) begin
         errFlag <= 1'b0;
      end
   end

   assign ready = !(flashBusy || eepromBusy); // R15 R16

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         statusLevel <= 1'b1;
         errorLevel <= 1'b1;
      end else begin
         statusLevel <= ready; // R12
         errorLevel <= !errFlag; // R13
      end
   end

   // Open-drain only ever pulls low, so several devices can share a line
   assign progBusyStatusOut = openDrain ? 1'b0 : statusLevel; // R17
   assign progErrorOut = openDrain ? 1'b0 : errorLevel;
   assign progBusyStatusOe_n = !(pinsActive && extEnable)
      || (openDrain && statusLevel); // R5 R17
   assign progErrorOe_n = !(pinsActive && extEnable)
      || (openDrain && errorLevel);

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_pin_enable: assert property ( // R1
      (nvmDedicateBit || runtimeEn || pinEnableProductTerm || blankDevice)
      |-> pinsActive)
      else $error("pins not enabled with a source set");

   a_pin_release: assert property ( // R2
      !pinsActive |-> tdoOe_n && progBusyStatusOe_n && progErrorOe_n)
      else $error("pin driven while port released");

   a_dedicated_hold: assert property ( // R3
      (dedicated && devResetActive) |=> (tapState != TAP_RESET
      || $past(tapState) == TAP_RESET || $past(tckRise)))
      else $error("dedicated port disturbed by reset");

   a_tdo_turnaround: assert property ( // R4
      $rose(tdoEnabled) |-> $past(entryUpdate))
      else $error("output pin enabled without entry command");

   a_ext_enable: assert property ( // R5
      entryUpdate && !tapForce |=> extEnable
      == $past(drShift[CFG_EXT_ENABLE_BIT]))
      else $error("extension enable not taken from entry command");

   a_reg_write: assert property ( // R6
      (regWrite && regHit && !devResetActive) |=> runtimeEn
      == $past(regWdata[RUNTIME_ENABLE_BIT]))
      else $error("runtime enable write not stored");

   a_reset_clear: assert property ( // R7
      devResetActive |=> !runtimeEn)
      else $error("runtime enable survived device reset");

   a_error_set: assert property ( // R13
      errSet |=> errFlag ##1 !progErrorOut || openDrain)
      else $error("flash failure did not raise error");

   a_error_cause: assert property ( // R14
      $rose(errFlag) |-> $past(errSet))
      else $error("error raised without a flash failure");

   a_status_level: assert property ( // R16
      (flashBusy || eepromBusy) [*2] |-> !statusLevel)
      else $error("status high while memory busy");

   a_reset_abort: assert property ( // R19
      (devResetActive && !dedicated) |=> tapState == TAP_RESET
      && !configMode)
      else $error("runtime port not aborted by reset");

   a_reg_readback: assert property ( // R18
      (regRead && regHit) |=> regRdata == {7'h00, $past(runtimeEn)})
      else $error("runtime enable readback wrong");

   a_eeprom_ignored: assert property ( // R14
      (eepromFail && !errSet && !errFlag) |=> !errFlag)
      else $error("eeprom failure raised error");

   a_status_ready: assert property ( // R15
      !(flashBusy || eepromBusy) |=> statusLevel)
      else $error("status low while memories idle");

   a_strobe_mode: assert property ( // R11
      (iscWriteStrobe || iscEraseStrobe) |-> $past(configMode))
      else $error("memory request outside configuration mode");

endmodule

// >>> hw/isp_port_pkg.sv
// Constants and types shared by the serial test port control block.
// Assumes a single 200 MHz clock domain for all users of this package.
package isp_port_pkg;

   // Runtime enable register, reached at control_block_base + offset
   localparam logic [7:0] RUNTIME_ENABLE_OFFSET = 8'hC7;
   localparam int RUNTIME_ENABLE_BIT = 0;
   localparam logic [7:0] RUNTIME_ENABLE_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

   // Instruction register
   localparam int IR_WIDTH = 4;
   localparam logic [3:0] IR_CAPTURE_PATTERN = 4'h1;
   localparam logic [3:0] CMD_CONFIG_ENTRY = 4'h8;
   localparam logic [3:0] CMD_CONFIG_EXIT = 4'h9;
   localparam logic [3:0] CMD_ERROR_CLEAR = 4'hA;
   localparam logic [3:0] CMD_PROGRAM_BYTE = 4'hB;
   localparam logic [3:0] CMD_READ_STATUS = 4'hC;
   localparam logic [3:0] CMD_ERASE_SECTOR = 4'hD;
   localparam logic [3:0] CMD_BYPASS = 4'hF;

   // Field positions in the entry command data register
   localparam int CFG_EXT_ENABLE_BIT = 0;
   localparam int CFG_OPEN_DRAIN_BIT = 1;
   // Field positions in the status data register
   localparam int STAT_READY_BIT = 0;
   localparam int STAT_ERROR_BIT = 1;

   typedef enum logic [3:0] {
      TAP_RESET = 4'h0,
      TAP_IDLE = 4'h1,
      SEL_DR = 4'h2,
      CAP_DR = 4'h3,
      SHIFT_DR = 4'h4,
      EXIT1_DR = 4'h5,
      PAUSE_DR = 4'h6,
      EXIT2_DR = 4'h7,
      UPD_DR = 4'h8,
      SEL_IR = 4'h9,
      CAP_IR = 4'hA,
      SHIFT_IR = 4'hB,
      EXIT1_IR = 4'hC,
      PAUSE_IR = 4'hD,
      EXIT2_IR = 4'hE,
      UPD_IR = 4'hF
   } tapState_t;

endpackage

// >>> hw/pin_sync.sv
// Two-stage synchroniser for pins arriving from outside the clock domain.
// Assumes the inputs are levels that stay stable for several clocks.
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,              // System clock
   input wire logic rst_n,              // Synchronous reset
   input wire logic [WIDTH-1:0] async,  // Raw pin levels
   output logic [WIDTH-1:0] synced      // Levels safe for logic
);
   logic [WIDTH-1:0] meta;

   if (WIDTH < 1) begin : badWidth
      $error("pin_sync: WIDTH must be at least 1");
   end

   // First stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta <= '0;
         synced <= '0;
      end else begin
         meta <= async;
         synced <= meta;
      end
   end
endmodule

// >>> hw/tap_fsm.sv
// Test access port state machine, advanced on detected test clock rises.
// Assumes tckRise is a one-cycle pulse and tms is already synchronised.
module tap_fsm
   import isp_port_pkg::*;
(
   input wire logic clock,        // System clock
   input wire logic rst_n,        // Synchronous reset
   input wire logic tckRise,      // One-cycle pulse per test clock rise
   input wire logic tms,          // Mode select, synchronised
   input wire logic forceReset,   // Holds the port in reset
   output tapState_t state        // Current port state
);
   tapState_t next_state;

   always_comb begin
      case (state)
         TAP_RESET: next_state = tms ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: next_state = tms ? SEL_DR : TAP_IDLE;
         SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
         CAP_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
         SHIFT_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
         EXIT1_DR: next_state = tms ? UPD_DR : PAUSE_DR;
         PAUSE_DR: next_state = tms ? EXIT2_DR : PAUSE_DR;
         EXIT2_DR: next_state = tms ? UPD_DR : SHIFT_DR;
         UPD_DR: next_state = tms ? SEL_DR : TAP_IDLE;
         SEL_IR: next_state = tms ? TAP_RESET : CAP_IR;
         CAP_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
         SHIFT_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
         EXIT1_IR: next_state = tms ? UPD_IR : PAUSE_IR;
         PAUSE_IR: next_state = tms ? EXIT2_IR : PAUSE_IR;
         EXIT2_IR: next_state = tms ? UPD_IR : SHIFT_IR;
         UPD_IR: next_state = tms ? SEL_DR : TAP_IDLE;
         default: next_state = TAP_RESET;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n || forceReset) begin
         state <= TAP_RESET;
      end else if (tckRise) begin
         state <= next_state;
      end
   end
endmodule

// >>> bench/jtag_ctrl_model.sv
// Behavioural external programming controller driving the serial test pins.
// Assumes the bench calls its tasks; test clock idles low between frames.
module jtag_ctrl_model (
   input wire logic tdoOut,       // Test data out level from the device
   input wire logic tdoOe_n,      // Low while the device drives test data out
   input wire logic ptRequest,    // Bench asks for the cable enable line
   output logic cableEnableLine,  // Tied to the product term enable node
   output logic tck,              // Test clock, 80 ns period inside frames
   output logic tms,              // Test mode select
   output logic tdi               // Test data in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic lastTdo;

   assign cableEnableLine = ptRequest;

   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      lastTdo = 1'b1;
   end

   // Data is set while the clock is low and sampled on the rise
   task automatic tap_bit(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #40 tck = 1'b1;
      // A released output line has no pull: read the inverse of its last level
      q = tdoOe_n ? ~lastTdo : tdoOut;
      lastTdo = q;
      #40 tck = 1'b0;
   endtask

   task automatic goto_idle();
      logic q;
      for (int i = 0; i < 5; i++) begin
         tap_bit(1'b1, 1'b0, q);
      end
      tap_bit(1'b0, 1'b0, q);
   endtask

   // From idle: scan n bits LSB first into IR or DR, finish back in idle
   task automatic scan(input bit ir, input logic [7:0] din, input int n,
                       output logic [7:0] dout);
      logic q;
      dout = 8'h00;
      tap_bit(1'b1, 1'b0, q);
      if (ir) begin
         tap_bit(1'b1, 1'b0, q);
      end
      tap_bit(1'b0, 1'b0, q);
      tap_bit(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         tap_bit(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tap_bit(1'b1, 1'b0, q);
      tap_bit(1'b0, 1'b0, q);
   endtask
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the serial test port control block.
// Assumes the controller model drives the test pins; bench drives the rest.
module tb_top;
   import isp_port_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic clock, rst_n, deviceReset_n, nvmDedicateBit, blankDevice;
   logic ptRequest, cableEnableLine, regWrite, regRead;
   logic [7:0] regAddr, regWdata, regRdata, iscData;
   logic tck, tms, tdi, tdoOut, tdoOe_n, pinsActive;
   logic flashBusy, eepromBusy, flashEraseFail, flashProgFail, eepromFail;
   logic progBusyStatusOut, progBusyStatusOe_n, progErrorOut, progErrorOe_n;
   logic configMode, iscWriteStrobe, iscEraseStrobe;
   int errTotal = 0;
   int nCompared = 0;
   int seed = 32'hA6AD;
   logic [7:0] rd, din, dout, irOut, strobeData;
   logic [7:0] strobeCount = 8'h00;
   logic [31:0] v;

   isp_port_control #(.DR_WIDTH(8)) dut (
      .clock(clock), .rst_n(rst_n), .deviceReset_n(deviceReset_n),
      .nvmDedicateBit(nvmDedicateBit), .blankDevice(blankDevice),
      .pinEnableProductTerm(cableEnableLine), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
      .regRdata(regRdata), .tckPin(tck), .tmsPin(tms), .tdiPin(tdi),
      .tdoOut(tdoOut), .tdoOe_n(tdoOe_n), .pinsActive(pinsActive),
      .flashBusy(flashBusy), .eepromBusy(eepromBusy),
      .flashEraseFail(flashEraseFail), .flashProgFail(flashProgFail),
      .eepromFail(eepromFail), .progBusyStatusOut(progBusyStatusOut),
      .progBusyStatusOe_n(progBusyStatusOe_n), .progErrorOut(progErrorOut),
      .progErrorOe_n(progErrorOe_n), .configMode(configMode),
      .iscWriteStrobe(iscWriteStrobe), .iscEraseStrobe(iscEraseStrobe),
      .iscData(iscData));

   jtag_ctrl_model ctrl (
      .tdoOut(tdoOut), .tdoOe_n(tdoOe_n), .ptRequest(ptRequest),
      .cableEnableLine(cableEnableLine), .tck(tck), .tms(tms), .tdi(tdi));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Memory requests last one cycle: catch them mid-cycle
   always @(negedge clock) begin
      if (iscWriteStrobe || iscEraseStrobe) begin
         strobeData <= iscData;
         strobeCount <= strobeCount + (iscWriteStrobe ? 8'h01 : 8'h10);
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string what);
      nCompared++;
      if (seen !== exp) begin
         errTotal++;
         $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      cycles(1);
      regWrite = 1'b0;
      cycles(1);
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      regAddr = a;
      regRead = 1'b1;
      cycles(1);
      regRead = 1'b0;
      cycles(1);
      d = regRdata;
   endtask

   // Instruction scan then a data scan of the given length
   task automatic cmd(input logic [3:0] op, input logic [7:0] d, input int n);
      ctrl.scan(1'b1, {4'h0, op}, IR_WIDTH, irOut);
      ctrl.scan(1'b0, d, n, dout);
      cycles(8);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      cycles(1);
      s = 1'b0;
      cycles(4);
   endtask

   function automatic logic [7:0] bypass_out(input logic [7:0] d);
      return {d[6:0], 1'b0};
   endfunction

   task automatic end_of_test();
      $display("Compared %0d values, %0d mismatches", nCompared, errTotal);
      if (errTotal == 0 && nCompared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #200us;
      errTotal++;
      end_of_test();
   end

   initial begin
      rst_n = 1'b0;
      deviceReset_n = 1'b1;
      nvmDedicateBit = 1'b0;
      blankDevice = 1'b0;
      ptRequest = 1'b0;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWdata = 8'h00;
      flashBusy = 1'b0;
      eepromBusy = 1'b0;
      flashEraseFail = 1'b0;
      flashProgFail = 1'b0;
      eepromFail = 1'b0;
      cycles(6);
      rst_n = 1'b1;
      cycles(3);
      reg_read(RUNTIME_ENABLE_OFFSET, rd);
      check(rd, RUNTIME_ENABLE_RESET, "enable reset value");
      check(pinsActive, 1'b0, "pins free after reset");
      check(tdoOe_n, 1'b1, "output off after reset");
      check({progBusyStatusOe_n, progErrorOe_n}, 2'b11, "ext off");
      // Random enable sources, register bits and unmapped addresses
      for (int i = 0; i < 24; i++) begin
         v = $random(seed);
         nvmDedicateBit = v[8];
         blankDevice = v[9];
         ptRequest = v[10];
         reg_write(RUNTIME_ENABLE_OFFSET, v[7:0]);
         reg_read(RUNTIME_ENABLE_OFFSET, rd);
         check(rd, {7'h00, v[0]}, "enable readback");
         check(pinsActive, v[8] | v[9] | v[10] | v[0], "or");
         din = (v[23:16] == RUNTIME_ENABLE_OFFSET) ? 8'h00 : v[23:16];
         reg_read(din, rd);
         check(rd, UNMAPPED_READ_VALUE, "unmapped read");
      end
      nvmDedicateBit = 1'b0;
      blankDevice = 1'b0;
      ptRequest = 1'b0;
      reg_write(RUNTIME_ENABLE_OFFSET, 8'h00);
      check(pinsActive, 1'b0, "software clear");
      // Port enabled at runtime: output stays off until the entry command
      reg_write(RUNTIME_ENABLE_OFFSET, 8'h01);
      ctrl.goto_idle();
      cmd(CMD_BYPASS, 8'h5A, 8);
      check(tdoOe_n, 1'b1, "output before entry");
      cmd(CMD_CONFIG_ENTRY, 8'h01, 8);
      check({configMode, tdoOe_n}, 2'b10, "entry turns output on");
      check({progBusyStatusOe_n, progErrorOe_n}, 2'b00, "ext on");
      // A boundary-scan opcode behaves as the one-bit bypass path
      din = v[31:24];
      ctrl.scan(1'b1, 8'h00, IR_WIDTH, irOut);
      check(irOut, {4'h0, IR_CAPTURE_PATTERN}, "capture pattern");
      ctrl.scan(1'b0, din, 8, dout);
      check(dout, bypass_out(din), "no boundary scan");
      for (int k = 0; k < 4; k++) begin
         flashBusy = k[0];
         eepromBusy = k[1];
         cycles(3);
         check(progBusyStatusOut, k == 0, "busy pin");
      end
      flashBusy = 1'b0;
      eepromBusy = 1'b0;
      pulse(eepromFail);
      check(progErrorOut, 1'b1, "eeprom fail ignored");
      pulse(flashEraseFail);
      check(progErrorOut, 1'b0, "erase fail");
      cycles(40);
      check(progErrorOut, 1'b0, "error holds");
      cmd(CMD_ERROR_CLEAR, 8'h00, 8);
      check(progErrorOut, 1'b1, "error cleared");
      pulse(flashProgFail);
      check(progErrorOut, 1'b0, "program fail");
      cmd(CMD_ERROR_CLEAR, 8'h00, 8);
      check(progErrorOut, 1'b1, "error cleared again");
      // Open-drain: released while high, pulled low while busy
      cmd(CMD_CONFIG_ENTRY, 8'h03, 8);
      check({progBusyStatusOe_n, progBusyStatusOut}, 2'b10, "od idle");
      flashBusy = 1'b1;
      cycles(3);
      check({progBusyStatusOe_n, progBusyStatusOut}, 2'b00, "od busy");
      flashBusy = 1'b0;
      // Program and erase requests carry the scanned byte
      v = $random(seed);
      cmd(CMD_PROGRAM_BYTE, v[7:0], 8);
      check(strobeData, v[7:0], "program data");
      cmd(CMD_ERASE_SECTOR, v[15:8], 8);
      check(strobeData, v[15:8], "erase data");
      check(strobeCount, 8'h11, "one request each");
      // Status scan shows ready and a latched flash error
      pulse(flashProgFail);
      ctrl.scan(1'b1, {4'h0, CMD_READ_STATUS}, IR_WIDTH, irOut);
      ctrl.scan(1'b0, 8'h00, 8, dout);
      check(dout, 8'h03, "status scan");
      cmd(CMD_CONFIG_EXIT, 8'h00, 8);
      check({configMode, progErrorOe_n}, 2'b01, "exit");
      // Device reset aborts runtime use and ignores writes meanwhile
      deviceReset_n = 1'b0;
      cycles(6);
      reg_write(RUNTIME_ENABLE_OFFSET, 8'h01);
      reg_read(RUNTIME_ENABLE_OFFSET, rd);
      check(rd, 8'h00, "reset clears enable");
      check(pinsActive, 1'b0, "reset frees pins");
      check(progErrorOut, 1'b1, "reset after exit");
      deviceReset_n = 1'b1;
      cycles(4);
      // Dedicated port survives device reset
      nvmDedicateBit = 1'b1;
      cycles(2);
      ctrl.goto_idle();
      cmd(CMD_CONFIG_ENTRY, 8'h01, 8);
      deviceReset_n = 1'b0;
      cycles(6);
      check({pinsActive, configMode}, 2'b11, "dedicated kept");
      deviceReset_n = 1'b1;
      cycles(4);
      end_of_test();
   end
endmodule
